// File: logic/ccem_pkg.sv
// Package of constants for the control channel error monitor.
package ccem_pkg;

  // ==========================================================================
  // Register map (byte addresses on the Wishbone bus, index times four).
  // ==========================================================================
  // Register indices; one register per bus word, so the byte address is index * 4.
  localparam logic [7:0] status_index = 8'h6d;
  localparam logic [7:0] config_index = 8'h6e;
  localparam logic [7:0] irq_enable_index = 8'h78;
  localparam logic [7:0] irq_clear_index = 8'h79;
  localparam logic [9:0] status_addr = {status_index, 2'b00};
  localparam logic [9:0] config_addr = {config_index, 2'b00};
  localparam logic [9:0] irq_enable_addr = {irq_enable_index, 2'b00};
  localparam logic [9:0] irq_clear_addr = {irq_clear_index, 2'b00};

  // ==========================================================================
  // Status field positions.
  // ==========================================================================
  localparam int master_err_bit = 4;
  localparam int master_to_bit = 3;
  localparam int slave_err_bit = 2;
  localparam int slave_to_bit = 1;
  localparam int resp_err_bit = 0;
  localparam logic [7:0] status_reset = 8'h00;

  // ==========================================================================
  // Configuration field positions and reset value.
  // ==========================================================================
  localparam int remote_disable_bit = 5;
  localparam int term_on_err_bit = 4;
  localparam int ack_remote_read_bit = 2;
  localparam int data_check_bit = 1;
  localparam int enh_enable_bit = 0;
  localparam logic [7:0] config_reset = 8'h20;
  // Writable configuration bits; bits 7 and 6 are reserved read-only zero.
  localparam logic [7:0] config_write_mask = 8'h3f;

  // ==========================================================================
  // Transaction tracker states.
  // ==========================================================================
  typedef enum logic [1:0]
  {
    ccem_idle = 2'b00,
    ccem_wait = 2'b01,
    ccem_abort = 2'b10
  } ccem_state_type;

endpackage : ccem_pkg

// File: logic/ccem_event_latch.sv
// Sticky event flags with read-clear where a fresh event wins.
module ccem_event_latch
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] set_i,
  input wire logic clear_i,
  output logic [4:0] flags_o
);

  // ==========================================================================
  // Flag storage.
  // ==========================================================================
  // A set in the clear cycle survives, so no event is ever lost.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flags_o <= 5'h00;
    end
    else if (clear_i)
    begin
      flags_o <= set_i;
    end
    else
    begin
      flags_o <= flags_o | set_i;
    end
  end

endmodule : ccem_event_latch

// File: logic/ccem_echo_check.sv
// Echo comparator: remembers each sent data byte and checks the response.
module ccem_echo_check
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sent_valid_i,
  input wire logic [7:0] sent_data_i,
  input wire logic resp_valid_i,
  input wire logic [7:0] resp_data_i,
  input wire logic resp_fault_i,
  input wire logic check_enable_i,
  output logic mismatch_o
);

  // ==========================================================================
  // Byte memory and compare.
  // ==========================================================================
  // The last byte sent forward, awaiting its echo.
  logic [7:0] sent_byte;
  // Set while a sent byte has not yet been echoed.
  logic pending;

  // Capture each forward byte.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sent_byte <= 8'h00;
      pending <= 1'b0;
    end
    else if (sent_valid_i)
    begin
      sent_byte <= sent_data_i;
      pending <= 1'b1;
    end
    else if (resp_valid_i)
    begin
      pending <= 1'b0;
    end
  end

  // Flag mismatches or faulty responses as a one-cycle pulse.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mismatch_o <= 1'b0;
    end
    else
    begin
      mismatch_o <= check_enable_i & resp_valid_i & pending & (resp_fault_i | (resp_data_i != sent_byte));
    end
  end

endmodule : ccem_echo_check

// File: logic/ccem_monitor.sv
// Control channel error monitor: status flags, configuration and Wishbone slave.
// What this block does
// (R1) Link error while master waits sets flag
// (R2) Watchdog expiry while master waits sets flag
// (R3) Link error while slave waits sets flag
// (R4) Watchdog expiry while slave waits sets flag
// (R5) Far end echoes each sent data byte
// (R6) Echo mismatch or fault sets response flag
// (R7) Flags sticky, cleared by status read
// (R8) Remote-disable bit blocks remote master access
// (R9) Local register access always still works
// (R10) Terminate-on-error aborts transaction on CRC
// (R11) Terminate ignored when enhanced checking off
// (R12) Enhanced checking only while enable bit set
// (R13) Event during read-clear stays set
module ccem_monitor
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Channel activity from the control channel engine.
  input wire logic master_wait_i,
  input wire logic slave_wait_i,
  input wire logic crc_error_i,
  input wire logic lock_lost_i,
  input wire logic watchdog_expired_i,
  input wire logic sent_valid_i,
  input wire logic [7:0] sent_data_i,
  input wire logic resp_valid_i,
  input wire logic [7:0] resp_data_i,
  input wire logic resp_fault_i,
  // Local I2C master request classification.
  input wire logic i2c_req_i,
  input wire logic i2c_remote_i,
  // Outputs to the engine.
  output logic remote_grant_o,
  output logic remote_block_o,
  output logic abort_o,
  output logic ack_remote_read_o,
  output logic irq_o
);

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  // Decode one word address, ignoring the two byte-offset bits.
  function automatic logic ccem_hit(input logic [9:0] adr, input logic [9:0] target);
    ccem_hit = (adr[9:2] == target[9:2]);
  endfunction : ccem_hit

  // ==========================================================================
  // Register state.
  // ==========================================================================
  // Configuration register.
  logic [7:0] config_reg;
  // Interrupt enable register, same layout as status.
  logic [4:0] irq_enable;
  // Interrupt-side sticky copy of the events, cleared by a write.
  logic [4:0] irq_status;
  // Sticky error flags read in the status register.
  logic [4:0] flags;
  // Event vector for this cycle.
  logic [4:0] events;
  // Echo mismatch pulse.
  logic resp_mismatch;
  // Bus access this cycle, not yet answered.
  logic access;
  // Read of the status register that clears it.
  logic status_read;
  // Tracker state.
  ccem_pkg::ccem_state_type state;
  ccem_pkg::ccem_state_type next_state;

  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;

  // ==========================================================================
  // Event detection.
  // ==========================================================================
  // Link errors and timeouts count only while a response is awaited.
  always_comb
  begin
    events = 5'h00;
    // (R1) master link error
    events[ccem_pkg::master_err_bit] = master_wait_i & (crc_error_i | lock_lost_i);
    // (R2) master watchdog timeout
    events[ccem_pkg::master_to_bit] = master_wait_i & watchdog_expired_i;
    // (R3) slave link error
    events[ccem_pkg::slave_err_bit] = slave_wait_i & (crc_error_i | lock_lost_i);
    // (R4) slave watchdog timeout
    events[ccem_pkg::slave_to_bit] = slave_wait_i & watchdog_expired_i;
    // (R6) response data error
    events[ccem_pkg::resp_err_bit] = resp_mismatch;
  end

  // The echo checker relies on the far end returning each byte.
  // (R5) echo expected back
  // (R12) check gated by enable
  ccem_echo_check u_echo
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sent_valid_i(sent_valid_i),
    .sent_data_i(sent_data_i),
    .resp_valid_i(resp_valid_i),
    .resp_data_i(resp_data_i),
    .resp_fault_i(resp_fault_i),
    .check_enable_i(config_reg[ccem_pkg::enh_enable_bit] & config_reg[ccem_pkg::data_check_bit]),
    .mismatch_o(resp_mismatch)
  );

  // ==========================================================================
  // Status flags.
  // ==========================================================================
  // (R7) clear on status read
  assign status_read = access & ~wb_we_i & ccem_hit(wb_adr_i, ccem_pkg::status_addr);

  // (R13) set beats read-clear
  ccem_event_latch u_flags
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(events),
    .clear_i(status_read),
    .flags_o(flags)
  );

  // ==========================================================================
  // Configuration and interrupt registers.
  // ==========================================================================
  // Software writes to configuration, honouring byte lane 0.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      config_reg <= ccem_pkg::config_reset;
    end
    else if (access & wb_we_i & wb_sel_i[0] & ccem_hit(wb_adr_i, ccem_pkg::config_addr))
    begin
      config_reg <= wb_dat_i[7:0] & ccem_pkg::config_write_mask;
    end
  end

  // Interrupt enable register.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_enable <= 5'h00;
    end
    else if (access & wb_we_i & wb_sel_i[0] & ccem_hit(wb_adr_i, ccem_pkg::irq_enable_addr))
    begin
      irq_enable <= wb_dat_i[4:0];
    end
  end

  // Interrupt status: write-one-to-clear, a same-cycle event still wins.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_status <= 5'h00;
    end
    else if (access & wb_we_i & wb_sel_i[0] & ccem_hit(wb_adr_i, ccem_pkg::irq_clear_addr))
    begin
      irq_status <= (irq_status & ~wb_dat_i[4:0]) | events;
    end
    else
    begin
      irq_status <= irq_status | events;
    end
  end

  // Level interrupt from registered state; one cycle behind the status bit.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(irq_status & irq_enable);
    end
  end

  // ==========================================================================
  // Wishbone answer.
  // ==========================================================================
  // Every access is answered one cycle after it is seen; unmapped gets err.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      if (access)
      begin
        if (ccem_hit(wb_adr_i, ccem_pkg::status_addr))
        begin
          wb_ack_o <= 1'b1;
          // The read returns flags before this cycle's clear; a same-cycle event stays for next read.
          wb_dat_o <= {27'h0, flags};
        end
        else if (ccem_hit(wb_adr_i, ccem_pkg::config_addr))
        begin
          wb_ack_o <= 1'b1;
          wb_dat_o <= {24'h0, config_reg};
        end
        else if (ccem_hit(wb_adr_i, ccem_pkg::irq_enable_addr))
        begin
          wb_ack_o <= 1'b1;
          wb_dat_o <= {27'h0, irq_enable};
        end
        else if (ccem_hit(wb_adr_i, ccem_pkg::irq_clear_addr))
        begin
          // Write-only clear register reads as zero.
          wb_ack_o <= 1'b1;
        end
        else
        begin
          wb_err_o <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Local I2C master access gating.
  // ==========================================================================
  // Remote requests are blocked while the disable bit is set; local ones always pass.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      remote_grant_o <= 1'b0;
      remote_block_o <= 1'b0;
    end
    else
    begin
      // (R8) remote access gating
      remote_grant_o <= i2c_req_i & i2c_remote_i & ~config_reg[ccem_pkg::remote_disable_bit];
      remote_block_o <= i2c_req_i & i2c_remote_i & config_reg[ccem_pkg::remote_disable_bit];
      // (R9) local access unaffected: local requests never reach either output.
    end
  end

  // Remote-read acknowledge helper is only meaningful under enhanced checking.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_remote_read_o <= 1'b0;
    end
    else
    begin
      ack_remote_read_o <= config_reg[ccem_pkg::enh_enable_bit] & config_reg[ccem_pkg::ack_remote_read_bit];
    end
  end

  // ==========================================================================
  // Transaction tracker and abort.
  // ==========================================================================
  // Decide whether a CRC error ends the active transaction.
  always_comb
  begin
    next_state = state;
    case (state)
      ccem_pkg::ccem_idle:
      begin
        if (master_wait_i | slave_wait_i)
        begin
          next_state = ccem_pkg::ccem_wait;
        end
      end
      ccem_pkg::ccem_wait:
      begin
        // (R10) abort on CRC
        // (R11) needs enhanced checking
        if (crc_error_i & config_reg[ccem_pkg::term_on_err_bit] & config_reg[ccem_pkg::enh_enable_bit])
        begin
          next_state = ccem_pkg::ccem_abort;
        end
        else if (~(master_wait_i | slave_wait_i))
        begin
          next_state = ccem_pkg::ccem_idle;
        end
      end
      ccem_pkg::ccem_abort:
      begin
        // Hold abort until the engine drops its wait.
        if (~(master_wait_i | slave_wait_i))
        begin
          next_state = ccem_pkg::ccem_idle;
        end
      end
      default:
      begin
        next_state = ccem_pkg::ccem_idle;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ccem_pkg::ccem_idle;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Abort output, registered from the next state.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      abort_o <= 1'b0;
    end
    else
    begin
      abort_o <= (next_state == ccem_pkg::ccem_abort);
    end
  end

endmodule : ccem_monitor

// File: testbench/ccem_monitor_sva.sv
// Port checker for the control channel error monitor.
module ccem_monitor_sva
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic master_wait_i,
  input wire logic slave_wait_i,
  input wire logic crc_error_i,
  input wire logic i2c_req_i,
  input wire logic i2c_remote_i,
  input wire logic remote_grant_o,
  input wire logic remote_block_o,
  input wire logic abort_o
);
  // ==========================================================================
  // One clock domain, so clocking and reset are given once.
  // ==========================================================================
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o;
  endproperty
  a_answer: assert property (p_answer) else $error("bus request not answered");
  property p_pulse;
    wb_ack_o |=> !wb_ack_o && (wb_dat_o == 32'h0);
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack or data held too long");
  property p_excl;
    wb_ack_o |-> !wb_err_o;
  endproperty
  a_excl: assert property (p_excl) else $error("ack and err together");
  property p_block_cause;
    $rose(remote_block_o) |-> $past(i2c_req_i && i2c_remote_i);
  endproperty
  a_block_cause: assert property (p_block_cause) else $error("block without remote request");
  property p_gate_excl;
    !(remote_grant_o && remote_block_o);
  endproperty
  a_gate_excl: assert property (p_gate_excl) else $error("grant and block together");
  property p_gate_cause;
    remote_grant_o || remote_block_o |-> $past(i2c_req_i && i2c_remote_i);
  endproperty
  a_gate_cause: assert property (p_gate_cause) else $error("grant or block for a local request");
  property p_abort_rise;
    $rose(abort_o) |-> $past(crc_error_i) && $past(master_wait_i || slave_wait_i);
  endproperty
  a_abort_rise: assert property (p_abort_rise) else $error("abort without crc while waiting");
  property p_abort_hold;
    abort_o && (master_wait_i || slave_wait_i) |=> abort_o;
  endproperty
  a_abort_hold: assert property (p_abort_hold) else $error("abort dropped while waiting");
  property p_abort_end;
    abort_o && !master_wait_i && !slave_wait_i |-> ##[1:2] !abort_o;
  endproperty
  a_abort_end: assert property (p_abort_end) else $error("abort kept after waits ended");

  // Main scenarios reached.
  c_ack: cover property (wb_ack_o);
  c_abort: cover property ($rose(abort_o));
  c_block: cover property ($rose(remote_block_o));
endmodule : ccem_monitor_sva

// File: testbench/ccem_far_end.sv
// Behavioural far end: echoes each sent byte after a set delay.
module ccem_far_end
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sent_valid_i,
  input wire logic [7:0] sent_data_i,
  input wire logic corrupt_i,
  input wire logic fault_i,
  input wire logic [3:0] delay_i,
  output logic resp_valid_o,
  output logic [7:0] resp_data_o,
  output logic resp_fault_o
);
  logic [7:0] held; // Byte to return, bit 0 flipped when told to err.
  logic [3:0] cnt; // Cycles left before the answer.
  logic busy; // A response is pending.
  logic hf; // Fault to report with the answer.
  always_ff @(posedge clk_i)
  begin
    resp_valid_o <= 1'b0;
    resp_fault_o <= 1'b0;
    // Idle data toggles so a stale byte never looks valid.
    resp_data_o <= ~resp_data_o;
    if (rst_i)
    begin
      busy <= 1'b0;
      cnt <= 4'h0;
      held <= 8'h00;
      hf <= 1'b0;
      resp_data_o <= 8'h00;
    end
    else if (sent_valid_i)
    begin
      held <= sent_data_i ^ {7'h00, corrupt_i};
      hf <= fault_i;
      cnt <= delay_i;
      busy <= 1'b1;
    end
    else if (busy && cnt == 4'h0)
    begin
      resp_valid_o <= 1'b1;
      resp_data_o <= held;
      resp_fault_o <= hf;
      busy <= 1'b0;
    end
    else if (busy)
      cnt <= cnt - 4'h1;
  end
endmodule : ccem_far_end

// File: testbench/tb_ccem_monitor.sv
// Self-checking testbench for the control channel error monitor.
module tb_ccem_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mw = 0, sw = 0, crc = 0, lk = 0, wd = 0;
  logic sv = 0, req = 0, rem = 0, bad = 0, flt = 0, rv, rf, gr, bl, ab, arr, irq, ack, err, e;
  logic [9:0] adr = 0;
  logic [31:0] wdat = 0, rdo, q;
  logic [7:0] sd = 0, rd;
  logic [3:0] dly = 0;
  int error_cnt = 0, total_checks = 0;

  ccem_monitor ccem_monitor_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack), .wb_err_o(err),
    .master_wait_i(mw), .slave_wait_i(sw), .crc_error_i(crc), .lock_lost_i(lk), .watchdog_expired_i(wd),
    .sent_valid_i(sv), .sent_data_i(sd), .resp_valid_i(rv), .resp_data_i(rd), .resp_fault_i(rf),
    .i2c_req_i(req), .i2c_remote_i(rem), .remote_grant_o(gr), .remote_block_o(bl), .abort_o(ab),
    .ack_remote_read_o(arr), .irq_o(irq));
  ccem_far_end ccem_far_end_inst (.clk_i(clk_i), .rst_i(rst_i), .sent_valid_i(sv), .sent_data_i(sd),
    .corrupt_i(bad), .fault_i(flt), .delay_i(dly), .resp_valid_o(rv), .resp_data_o(rd), .resp_fault_o(rf));

  initial
  begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // Classic cycle: held until ack or err is sampled, then released for a cycle.
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    q = rdo;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20)
    begin
      error_cnt++;
      end_of_test();
    end
    @(posedge clk_i);
  endtask : bus

  task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rdc

  task automatic t_regs();
    rdc(ccem_pkg::config_addr, 32'h20);
    chk(arr, 1'b0);
    rdc(ccem_pkg::status_addr, 32'h0);
    bus(1'b1, ccem_pkg::config_addr, 32'hff);
    rdc(ccem_pkg::config_addr, 32'h3f);
    chk(arr, 1'b1);
    bus(1'b0, 10'h3fc, 32'h0);
    chk(e, 1'b1);
    bus(1'b1, ccem_pkg::status_addr, 32'hff);
    rdc(ccem_pkg::status_addr, 32'h0);
    bus(1'b1, ccem_pkg::config_addr, 32'h20);
    $display("t_regs done");
  endtask : t_regs

  // Each line: master wait, slave wait, crc, lock lost, watchdog.
  task automatic t_flags();
    logic [4:0] ev [7] = '{5'h14, 5'h12, 5'h11, 5'h0c, 5'h0a, 5'h09, 5'h04};
    logic [7:0] ex [7] = '{8'h10, 8'h10, 8'h08, 8'h04, 8'h04, 8'h02, 8'h00};
    for (int i = 0; i < 7; i++)
    begin
      {mw, sw} <= ev[i][4:3];
      @(posedge clk_i);
      {crc, lk, wd} <= ev[i][2:0];
      @(posedge clk_i);
      {mw, sw, crc, lk, wd} <= 5'h00;
      @(posedge clk_i);
      rdc(ccem_pkg::status_addr, {24'h0, ex[i]});
      rdc(ccem_pkg::status_addr, 32'h0);
    end
    $display("t_flags done");
  endtask : t_flags

  // Config, corrupt, fault, delay and expected status per line.
  task automatic t_echo();
    logic [7:0] cf [5] = '{8'h23, 8'h23, 8'h21, 8'h22, 8'h23};
    logic cr [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    logic fl [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [3:0] dl [5] = '{4'h1, 4'h5, 4'h2, 4'h2, 4'h3};
    logic [7:0] ex [5] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h01};
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, ccem_pkg::config_addr, {24'h0, cf[i]});
      bad <= cr[i];
      flt <= fl[i];
      dly <= dl[i];
      sv <= 1'b1;
      sd <= 8'h5a + 8'(i);
      @(posedge clk_i);
      sv <= 1'b0;
      repeat (12) @(posedge clk_i);
      rdc(ccem_pkg::status_addr, {24'h0, ex[i]});
    end
    bad <= 1'b0;
    flt <= 1'b0;
    $display("t_echo done");
  endtask : t_echo

  task automatic t_irq();
    for (int m = 1; m >= 0; m--)
    begin
      // Start from a clean interrupt status so only this event can raise the line.
      bus(1'b1, ccem_pkg::irq_clear_addr, 32'h1f);
      bus(1'b1, ccem_pkg::irq_enable_addr, m == 1 ? 32'h10 : 32'h0);
      chk(irq, 1'b0);
      mw <= 1'b1;
      @(posedge clk_i);
      crc <= 1'b1;
      @(posedge clk_i);
      {mw, crc} <= 2'b00;
      repeat (3) @(posedge clk_i);
      chk(irq, m[0]);
      rdc(ccem_pkg::status_addr, 32'h10);
      chk(irq, m[0]);
      bus(1'b1, ccem_pkg::irq_clear_addr, 32'h1f);
      @(posedge clk_i);
      chk(irq, 1'b0);
    end
    $display("t_irq done");
  endtask : t_irq

  task automatic t_gate();
    bus(1'b1, ccem_pkg::config_addr, 32'h20);
    {req, rem} <= 2'b11;
    repeat (2) @(posedge clk_i);
    chk({gr, bl}, 2'b01);
    bus(1'b1, ccem_pkg::config_addr, 32'h0);
    chk({gr, bl}, 2'b10);
    {req, rem} <= 2'b10;
    repeat (2) @(posedge clk_i);
    chk({gr, bl}, 2'b00);
    {req, rem} <= 2'b00;
    @(posedge clk_i);
    $display("t_gate done");
  endtask : t_gate

  // Terminate with enhanced on, enhanced off, and terminate off.
  task automatic t_abort();
    logic [7:0] cf [3] = '{8'h11, 8'h10, 8'h01};
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, ccem_pkg::config_addr, {24'h0, cf[i]});
      sw <= 1'b1;
      @(posedge clk_i);
      crc <= 1'b1;
      @(posedge clk_i);
      crc <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(ab, i == 0);
      sw <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(ab, 1'b0);
      rdc(ccem_pkg::status_addr, 32'h04);
    end
    $display("t_abort done");
  endtask : t_abort

  // A one-cycle event on the very edge that read-clears the status must survive.
  task automatic t_race();
    fork
      bus(1'b0, ccem_pkg::status_addr, 32'h0);
      begin
        {mw, crc} <= 2'b11;
        @(posedge clk_i);
        {mw, crc} <= 2'b00;
      end
    join
    chk(q, 32'h0);
    rdc(ccem_pkg::status_addr, 32'h10);
    rdc(ccem_pkg::status_addr, 32'h0);
    $display("t_race done");
  endtask : t_race

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_flags();
    t_echo();
    t_irq();
    t_gate();
    t_abort();
    t_race();
    end_of_test();
  end
endmodule : tb_ccem_monitor

bind ccem_monitor ccem_monitor_sva ccem_monitor_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .master_wait_i(master_wait_i), .slave_wait_i(slave_wait_i), .crc_error_i(crc_error_i),
  .i2c_req_i(i2c_req_i), .i2c_remote_i(i2c_remote_i), .remote_grant_o(remote_grant_o),
  .remote_block_o(remote_block_o), .abort_o(abort_o));
